// File: logic/text_string_pkg.sv
package text_string_pkg;

    // character and word geometry
    localparam int CHAR_W = 8;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int LEN_W = 13;
    localparam int CNT_W = 16;

    // limits on string length, count and start position
    localparam logic [LEN_W-1:0] MAX_CHARS = 13'h0FFF;
    localparam logic [CNT_W-1:0] MAX_COUNT = 16'h0FFF;
    localparam logic [CNT_W-1:0] MIN_START = 16'h0001;
    localparam logic [CNT_W-1:0] MAX_START = 16'h0FFF;

    // terminator codes
    localparam logic [CHAR_W-1:0] NUL_CHAR = 8'h00;
    localparam logic [WORD_W-1:0] NUL_WORD = 16'h0000;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_RST = 13'h0000;

    // string operations handled by the unit
    typedef enum logic [1:0] {
        OP_CONCAT,
        OP_LEFT,
        fetch_right_op,
        OP_MID
    } str_op_t;

    // operands supplied by the user program
    typedef struct packed {
        str_op_t op;
        logic [ADDR_W-1:0] source_string_operand;
        logic [ADDR_W-1:0] second_string;
        logic [ADDR_W-1:0] dest;
        logic [CNT_W-1:0] count_operand;
        logic [CNT_W-1:0] start_position_operand;
    } str_req_t;

    // word memory request, read data returns one cycle after rd rises
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [WORD_W-1:0] wdata;
    } mem_req_t;

endpackage

// File: logic/text_string_extract_unit.sv
`timescale 1ns/10ps
`default_nettype none

module text_string_extract_unit
    import text_string_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic exec_cond,
    input wire logic edge_mode,
    input wire str_req_t req,
    input wire logic [WORD_W-1:0] mem_rdata,
    output mem_req_t mem,
    output logic busy,
    output logic done,
    output logic error_flag,
    output logic equals_flag
);

    typedef enum {
        ST_IDLE,
        ST_SCAN_RD,
        ST_SCAN_REQ,
        ST_SCAN_DAT,
        ST_PLAN,
        ST_COPY_RD,
        ST_COPY_REQ,
        ST_COPY_DAT,
        ST_TAIL,
        ST_WR_END,
        ST_FINISH
    } state_t;

    state_t state;
    str_req_t cur;
    logic prior_cond;
    logic start;
    logic scan_sel;
    logic [ADDR_W-1:0] scan_word;
    logic [LEN_W-1:0] len_a;
    logic [LEN_W-1:0] len_b;
    logic [LEN_W-1:0] src_off;
    logic [LEN_W-1:0] n_out;
    logic [LEN_W-1:0] k;
    logic [CHAR_W-1:0] hi_byte;
    logic err;
    logic [LEN_W-1:0] scan_len;
    logic [LEN_W:0] next_scan_len;
    logic hi_nul;
    logic lo_nul;
    logic [LEN_W-1:0] char_pos;
    logic [ADDR_W-1:0] char_base;
    logic [CHAR_W-1:0] next_char;
    logic [LEN_W:0] cat_len;
    logic [LEN_W-1:0] mid_avail;
    logic [LEN_W-1:0] cnt_short;
    logic [LEN_W-1:0] start_idx;

    // trigger: level while held, or one shot on a rising edge
    // a condition already high when reset lifts counts as a rising edge
    assign start = (state == ST_IDLE) && exec_cond && (!edge_mode || !prior_cond);

    // condition as seen on the previous edge, for the one-shot trigger
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prior_cond <= 1'b0;
        end else begin
            prior_cond <= exec_cond;
        end
    end

    // operands are held for the whole operation
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else if (start) begin
            cur <= req;
        end
    end

    // scan: count characters of the word just read
    // a zero high byte ends the string before its low byte is looked at
    assign scan_len = scan_sel ? len_b : len_a;
    assign hi_nul = (mem_rdata[WORD_W-1:CHAR_W] == NUL_CHAR);
    assign lo_nul = (mem_rdata[CHAR_W-1:0] == NUL_CHAR);
    always_comb begin
        if (hi_nul) begin
            next_scan_len = {1'b0, scan_len};
        end else if (lo_nul) begin
            next_scan_len = {1'b0, scan_len} + 14'h0001;
        end else begin
            next_scan_len = {1'b0, scan_len} + 14'h0002;
        end
    end

    // planning terms: output length per operation
    assign cat_len = {1'b0, len_a} + {1'b0, len_b};
    assign cnt_short = cur.count_operand[LEN_W-1:0];
    assign start_idx = cur.start_position_operand[LEN_W-1:0] - 13'h0001;
    assign mid_avail = len_a - start_idx;

    // source character for output position k
    always_comb begin
        if (cur.op == OP_CONCAT && k >= len_a) begin
            char_base = cur.second_string;
            char_pos = k - len_a;
        end else begin
            char_base = cur.source_string_operand;
            char_pos = src_off + k;
        end
    end
    assign next_char = char_pos[0] ? mem_rdata[CHAR_W-1:0] : mem_rdata[WORD_W-1:CHAR_W];

    // operation sequencer
    // every refusal is decided before the first copy read, so a refused
    // operation never reaches the write states and the destination stays as it was
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            scan_sel <= 1'b0;
            scan_word <= ADDR_RST;
            len_a <= LEN_RST;
            len_b <= LEN_RST;
            src_off <= LEN_RST;
            n_out <= LEN_RST;
            k <= LEN_RST;
            hi_byte <= NUL_CHAR;
            err <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        scan_sel <= 1'b0;
                        scan_word <= req.source_string_operand;
                        len_a <= LEN_RST;
                        len_b <= LEN_RST;
                        k <= LEN_RST;
                        err <= 1'b0;
                        if (req.op != OP_CONCAT && req.count_operand > MAX_COUNT) begin
                            err <= 1'b1;
                            state <= ST_FINISH;
                        end else if (req.op == OP_MID && (req.start_position_operand < MIN_START ||
                                     req.start_position_operand > MAX_START)) begin
                            err <= 1'b1;
                            state <= ST_FINISH;
                        end else begin
                            state <= ST_SCAN_RD;
                        end
                    end
                end
                ST_SCAN_RD: begin
                    state <= ST_SCAN_REQ;
                end
                ST_SCAN_REQ: begin
                    state <= ST_SCAN_DAT;
                end
                ST_SCAN_DAT: begin
                    if (scan_sel) begin
                        len_b <= next_scan_len[LEN_W-1:0];
                    end else begin
                        len_a <= next_scan_len[LEN_W-1:0];
                    end
                    if (!hi_nul && !lo_nul && next_scan_len > {1'b0, MAX_CHARS}) begin
                        err <= 1'b1;
                        state <= ST_FINISH;
                    end else if (!hi_nul && !lo_nul) begin
                        scan_word <= scan_word + 16'h0001;
                        state <= ST_SCAN_RD;
                    end else if (cur.op == OP_CONCAT && !scan_sel) begin
                        scan_sel <= 1'b1;
                        scan_word <= cur.second_string;
                        state <= ST_SCAN_RD;
                    end else begin
                        state <= ST_PLAN;
                    end
                end
                ST_PLAN: begin
                    state <= ST_COPY_RD;
                    case (cur.op)
                        // an overlong joined result is cut to the maximum, not refused
                        OP_CONCAT: begin
                            src_off <= LEN_RST;
                            n_out <= (cat_len > {1'b0, MAX_CHARS}) ? MAX_CHARS : cat_len[LEN_W-1:0];
                        end
                        OP_LEFT: begin
                            src_off <= LEN_RST;
                            n_out <= (cnt_short > len_a) ? len_a : cnt_short;
                        end
                        fetch_right_op: begin
                            src_off <= (cnt_short > len_a) ? LEN_RST : len_a - cnt_short;
                            n_out <= (cnt_short > len_a) ? len_a : cnt_short;
                        end
                        OP_MID: begin
                            src_off <= start_idx;
                            n_out <= (cnt_short > mid_avail) ? mid_avail : cnt_short;
                            if (cur.start_position_operand[LEN_W-1:0] > len_a) begin
                                err <= 1'b1;
                                state <= ST_FINISH;
                            end
                        end
                        default: begin
                            state <= ST_FINISH;
                        end
                    endcase
                end
                ST_COPY_RD: begin
                    state <= (k == n_out) ? ST_TAIL : ST_COPY_REQ;
                end
                ST_COPY_REQ: begin
                    state <= ST_COPY_DAT;
                end
                ST_COPY_DAT: begin
                    if (!k[0]) begin
                        hi_byte <= next_char;
                    end
                    k <= k + 13'h0001;
                    state <= ST_COPY_RD;
                end
                ST_TAIL: begin
                    state <= ST_WR_END;
                end
                ST_WR_END: begin
                    state <= ST_FINISH;
                end
                ST_FINISH: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // memory port: reads for scan and copy, writes only after a clean scan
    // copy runs forward one character at a time: a destination at or below an overlapping first
    // source is safe, one above it or one over the second string of a join may read back what was just written
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mem <= '0;
        end else begin
            mem.rd <= 1'b0;
            mem.wr <= 1'b0;
            if (state == ST_SCAN_RD) begin
                mem.addr <= scan_word;
                mem.rd <= 1'b1;
            end else if (state == ST_COPY_RD && k != n_out) begin
                mem.addr <= char_base + {4'h0, char_pos[LEN_W-1:1]};
                mem.rd <= 1'b1;
            end else if (state == ST_COPY_DAT && k[0]) begin
                mem.addr <= cur.dest + {4'h0, k[LEN_W-1:1]};
                mem.wr <= 1'b1;
                mem.wdata <= {hi_byte, next_char};
            end else if (state == ST_TAIL) begin
                mem.addr <= cur.dest + {4'h0, k[LEN_W-1:1]};
                mem.wr <= 1'b1;
                mem.wdata <= k[0] ? {hi_byte, NUL_CHAR} : NUL_WORD;
            end
        end
    end

    // flags and handshake, refreshed at the end of every operation
    // equals means only the terminator word went out
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            error_flag <= 1'b0;
            equals_flag <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
        end else begin
            done <= (state == ST_FINISH);
            busy <= start || (state != ST_IDLE && state != ST_FINISH);
            if (state == ST_FINISH) begin
                error_flag <= err;
                equals_flag <= !err && (n_out == LEN_RST);
            end
        end
    end

endmodule // text_string_extract_unit

`default_nettype wire

// File: dv/text_string_mem.sv
`timescale 1ns/10ps
`default_nettype none

module text_string_mem
    import text_string_pkg::*;
(
    input wire logic mclk,
    input wire mem_req_t mem,
    output logic [WORD_W-1:0] mem_rdata
);
    logic [WORD_W-1:0] ram [0:4095];

    initial mem_rdata = 16'h5A5A;

    // one store holds every span; read answered in the next cycle, then scrambled
    always @(posedge mclk) begin
        if (mem.wr) begin
            ram[mem.addr[11:0]] <= mem.wdata;
        end
        mem_rdata <= mem.rd ? ram[mem.addr[11:0]] : ~mem_rdata;
    end
endmodule // text_string_mem

`default_nettype wire

// File: dv/text_string_chk.sv
`timescale 1ns/10ps
`default_nettype none

module text_string_chk
    import text_string_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic exec_cond,
    input wire logic edge_mode,
    input wire str_req_t req,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire mem_req_t mem,
    input wire logic busy,
    input wire logic done,
    input wire logic error_flag,
    input wire logic equals_flag
);
    logic [12:0] wcnt;
    logic [WORD_W-1:0] last_w;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // writes since the last done, and the last word written
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wcnt <= '0;
            last_w <= '0;
        end else begin
            wcnt <= done ? 13'h0000 : wcnt + 13'(mem.wr);
            if (mem.wr) begin
                last_w <= mem.wdata;
            end
        end
    end

    sequence s_start;
        $rose(busy);
    endsequence

    sequence s_fail;
        done && error_flag;
    endsequence

    AST_DONE_PULSE: assert property (done |=> !done) else $error("done too long");
    AST_FLAGS_HOLD: assert property (!done |-> $stable({error_flag, equals_flag})) else $error("flags moved");
    AST_ERR_NO_WRITE: assert property (s_fail |-> wcnt == 13'h0000) else $error("write on error");
    AST_EQ_ZERO_WORD: assert property (done && equals_flag |-> wcnt == 13'h0001 && last_w == NUL_WORD
        && !error_flag) else $error("equals without lone zero word");
    AST_TERMINATED: assert property (done && !error_flag |-> wcnt != 13'h0000 && last_w[7:0] == NUL_CHAR)
        else $error("result not terminated");
    AST_NOT_EQUAL: assert property (done && wcnt > 13'h0001 |-> !equals_flag) else $error("equals on text");
    AST_START_COND: assert property (s_start |-> $past(exec_cond) && (!$past(edge_mode) || !$past(exec_cond, 2)))
        else $error("start without trigger");
    AST_LEVEL_AGAIN: assert property (done && exec_cond && !edge_mode |-> ##[1:2] busy)
        else $error("no level retrigger");
    AST_CNT_ERR: assert property (s_start ##0 (req.op != OP_CONCAT && req.count_operand > MAX_COUNT)
        |-> ##[1:8] s_fail) else $error("count not refused");
    AST_POS_ERR: assert property (s_start ##0 (req.op == OP_MID && (req.start_position_operand < MIN_START
        || req.start_position_operand > MAX_START)) |-> ##[1:8] s_fail) else $error("start not refused");
endmodule // text_string_chk

`default_nettype wire

// File: dv/test_text_string_extract_unit.sv
`timescale 1ns/10ps
`default_nettype none

module test_text_string_extract_unit;
    import text_string_pkg::*;
    localparam logic [ADDR_W-1:0] SA = 16'h0010;
    localparam logic [ADDR_W-1:0] SB = 16'h0020;
    localparam logic [ADDR_W-1:0] SE = 16'h0030;
    localparam logic [ADDR_W-1:0] SU = 16'h0800;
    localparam logic [ADDR_W-1:0] DST = 16'h0100;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic exec_cond = 1'b0;
    logic edge_mode = 1'b1;
    str_req_t req = '0;
    logic [WORD_W-1:0] mem_rdata;
    mem_req_t mem;
    logic busy;
    logic done;
    logic error_flag;
    logic equals_flag;
    int err_count = 0;
    int samples_checked = 0;

    // clock and design with its word store
    initial forever #5 mclk = ~mclk;
    text_string_extract_unit dut (.mclk(mclk), .rst_b(rst_b), .exec_cond(exec_cond), .edge_mode(edge_mode),
        .req(req), .mem_rdata(mem_rdata), .mem(mem), .busy(busy), .done(done), .error_flag(error_flag),
        .equals_flag(equals_flag));
    text_string_mem u_mem (.mclk(mclk), .mem(mem), .mem_rdata(mem_rdata));

    function automatic logic [7:0] ch(input string s, input int i);
        return (i < s.len()) ? s[i] : 8'h00;
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    task automatic put(input logic [ADDR_W-1:0] a, input string s);
        for (int i = 0; i <= s.len() / 2; i++) u_mem.ram[a + i] = {ch(s, 2 * i), ch(s, 2 * i + 1)};
    endtask

    // one edge-triggered operation, then flags and destination judged
    task automatic go(input str_op_t op, input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] s2,
        input logic [CNT_W-1:0] n, input logic [CNT_W-1:0] p, input string x, input logic ee);
        int k;
        for (k = 0; k < 8; k++) u_mem.ram[DST + k] = 16'hA5A5;
        req = '{op, s, s2, DST, n, p};
        edge_mode = 1'b1;
        @(negedge mclk);
        exec_cond = 1'b1;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (done !== 1'b1 && k < 20000);
        chk("done", 16'h0001, 16'(done));
        exec_cond = 1'b0;
        chk("error_flag", 16'(ee), 16'(error_flag));
        chk("equals_flag", 16'(!ee && x.len() == 0), 16'(equals_flag));
        if (ee) chk("dest", 16'hA5A5, u_mem.ram[DST]);
        else for (k = 0; k <= x.len() / 2; k++) chk("dest", {ch(x, 2 * k), ch(x, 2 * k + 1)}, u_mem.ram[DST + k]);
    endtask

    task automatic t_left;
        go(OP_LEFT, SA, 0, 3, 0, "ABC", 0);
        go(OP_LEFT, SA, 0, 16'h0FFF, 0, "ABCDE", 0);
        go(OP_LEFT, SA, 0, 0, 0, "", 0);
        go(OP_LEFT, SA, 0, 16'h1000, 0, "", 1);
        go(OP_LEFT, SU, 0, 3, 0, "", 1);
    endtask

    task automatic t_right;
        go(fetch_right_op, SA, 0, 2, 0, "DE", 0);
        go(fetch_right_op, SA, 0, 7, 0, "ABCDE", 0);
        go(fetch_right_op, SA, 0, 0, 0, "", 0);
        go(fetch_right_op, SA, 0, 16'h1000, 0, "", 1);
    endtask

    task automatic t_mid;
        go(OP_MID, SA, 0, 3, 2, "BCD", 0);
        go(OP_MID, SA, 0, 9, 4, "DE", 0);
        go(OP_MID, SA, 0, 16'h0FFF, 1, "ABCDE", 0);
        go(OP_MID, SA, 0, 1, 6, "", 1);
        go(OP_MID, SA, 0, 1, 0, "", 1);
        go(OP_MID, SA, 0, 1, 16'h1000, "", 1);
        go(OP_MID, SA, 0, 16'h1000, 1, "", 1);
        go(OP_MID, SU, 0, 1, 1, "", 1);
    endtask

    task automatic t_cat;
        go(OP_CONCAT, SA, SB, 16'h1000, 0, "ABCDEFG", 0);
        go(OP_CONCAT, SE, SE, 0, 0, "", 0);
        go(OP_CONCAT, SU, SB, 0, 0, "", 1);
        go(OP_CONCAT, SA, SU, 0, 0, "", 1);
    endtask

    // condition held high for a while; counts the runs that follow
    task automatic runs(input logic m, input logic [15:0] e);
        int n;
        n = 0;
        req = '{OP_LEFT, SA, SA, DST, 16'h0001, 16'h0001};
        edge_mode = m;
        @(negedge mclk);
        exec_cond = 1'b1;
        repeat (300) begin
            @(negedge mclk);
            n += int'(done);
        end
        exec_cond = 1'b0;
        repeat (60) @(negedge mclk);
        chk("runs", e, 16'(n > 1 ? 2 : n));
    endtask

    task automatic final_report;
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        for (int i = 16'h0800; i < 4096; i++) u_mem.ram[i] = 16'h4141;
        put(SA, "ABCDE");
        put(SB, "FG");
        put(SE, "");
        t_left;
        t_right;
        t_mid;
        t_cat;
        runs(1'b0, 16'h0002);
        runs(1'b1, 16'h0001);
        final_report;
    end

    // watchdog against a hang; four unterminated scans of about 6200 cycles lead a run of some 26000
    initial begin
        repeat (60000) @(posedge mclk);
        err_count++;
        final_report;
    end
endmodule // test_text_string_extract_unit

bind text_string_extract_unit text_string_chk u_chk (.mclk(mclk), .rst_b(rst_b), .exec_cond(exec_cond),
    .edge_mode(edge_mode), .req(req), .mem_rdata(mem_rdata), .mem(mem), .busy(busy), .done(done),
    .error_flag(error_flag), .equals_flag(equals_flag));

`default_nettype wire
